// ==== pkg/phy_ext_params.svh ====
// offsets, field positions, reset values and strap mapping
`ifndef PHY_EXT_PARAMS_SVH
`define PHY_EXT_PARAMS_SVH
// register indices, byte address is four times the index
`define IDX_GOOD_CRC 5'h12
`define IDX_LOOP_CTRL 5'h13
`define IDX_POWER_CTRL 5'h14
`define IDX_PAGE_SELECT 5'h1F
`define EXT_PAGE_VALUE 16'h0001
`define PAGE_RESET 16'h0000
// good-crc register fields
`define CRC_CNT_W 14
`define F_PKT_SEEN 15
// loopback/signal-detect/led register fields
`define F_LED_HI 15
`define F_LED_LO 12
`define F_BLINK 11
`define F_MLB_EN 10
`define F_MLB_MODE 8
`define F_CLB_EN 7
`define F_CLB_MODE 5
`define F_FAST_FAIL 4
`define F_MDI 2
`define F_SIGNAL_DETECT_INPUT_POL 0
`define LOOP_WMASK 16'hFFFD
`define LOOP_RESET 16'h0000
// power-saving register fields
`define F_CARRIER 15
`define F_SLEEP 13
`define F_WAKE 11
`define F_ADDR_REV 9
`define F_CLK_FAST 8
`define F_MEDIA 6
`define F_NO_PRE 5
`define F_DS_EN 4
`define F_DS_CTL 2
`define F_DS_STAT 1
`define POWER_WMASK 16'hFB3C
`define POWER_RESET 16'h3804
`define DS_BASE 3'h2
// strap pin positions
`define STRAP_BLINK 0
`define STRAP_SIGNAL_DETECT_INPUT 1
`define STRAP_CLK_FAST 2
`define STRAP_DS_EN 3
`define STRAP_ADDR_REV 4
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== pkg/phy_ext_pkg.sv ====
// types shared by the extended control register bank
package phy_ext_pkg;
  typedef logic [15:0] reg16_t;
  typedef logic [4:0] reg_idx_t;
  typedef enum logic [1:0] {
    LB_PAD, LB_SERIAL, LB_PARALLEL, LB_RECOV_CLK
  } lb_kind_e;
  typedef enum logic [1:0] {
    MDI_AUTO, MDI_RSVD, MDI_FORCED, MDI_X_FORCED
  } mdi_mode_e;
endpackage

// ==== verilog/phy_extended_control_regs.sv ====
// extended page control registers behind an axi4-lite slave
// Functional notes
// - extended registers visible only when page is 0x0001
// - packet-seen bit set on receive, clears on read
// - 14-bit good-crc count wraps, clears on read
// - four led extended-mode bits, reset to zero
// - bit 11 enables led blink after reset
// - media loopback enable overrides far-end and isolate
// - mac loopback enable overrides far-end and isolate
// - two-bit loopback kind fields for media and mac
// - bit 4 enables fast link-failure pin
// - crossover field selects auto, mdi or mdi-x
// - signal-detect polarity bit, strap reset value
// - bit 15 disables carrier extension
// - sleep timer select, reset code 01
// - wake-up timer select, reset code 11
// - output clock fast select, port zero only
// - read-only active media status bits
// - no-preamble receive mode enable bit
// - downshift enable bit, strap reset value
// - downshift after 2 to 5 attempts
// - read-only downshift status bit
`timescale 1ns/1ps
`include "phy_ext_params.svh"
module phy_extended_control_regs #(
  parameter int ADDR_W = 8,
  parameter int STRAP_W = 5
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [ADDR_W-1:0] AWADDR_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  output logic BVALID_O,
  input wire logic BREADY_I,
  output logic [1:0] BRESP_O,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  input wire logic [ADDR_W-1:0] ARADDR_I,
  output logic RVALID_O,
  input wire logic RREADY_I,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  input wire logic GOOD_CRC_PKT_I,
  input wire logic [1:0] MEDIA_MODE_I,
  input wire logic DOWNSHIFT_STATUS_I,
  input wire logic PORT_ZERO_I,
  input wire logic [STRAP_W-1:0] CONFIG_STRAP_PINS_I,
  input wire logic SIGNAL_DETECT_INPUT_I,
  output logic [3:0] LED_EXT_MODE_O,
  output logic LED_RESET_BLINK_O,
  output logic MEDIA_LB_EN_O,
  output logic [1:0] MEDIA_LB_MODE_O,
  output logic MAC_LB_EN_O,
  output logic [1:0] MAC_LB_MODE_O,
  output logic LB_OVERRIDE_O,
  output logic FAST_FAILURE_PIN_EN_O,
  output logic [1:0] MDI_MODE_O,
  output logic SIGNAL_DETECT_INPUT_ACTIVE_LOW_O,
  output logic SIGNAL_DETECT_O,
  output logic CARRIER_EXT_DIS_O,
  output logic [1:0] SLEEP_SEL_O,
  output logic [1:0] WAKE_SEL_O,
  output logic ADDR_REVERSAL_O,
  output logic OUTPUT_CLOCK_FAST_O,
  output logic NO_PREAMBLE_EN_O,
  output logic DOWNSHIFT_EN_O,
  output logic [2:0] DOWNSHIFT_ATTEMPTS_O
);

  //////////////////////////////////////////////////////////////////////
  // helpers

  // true when the access is misaligned or outside the 32-word window
  function automatic logic addr_bad(input logic [ADDR_W-1:0] a);
    addr_bad = (a[1:0] != 2'h0) || (a[ADDR_W-1:7] != '0);
  endfunction

  // true when an index hits an extended register on the extended page
  function automatic logic ext_hit(input phy_ext_pkg::reg_idx_t idx,
                                   input phy_ext_pkg::reg_idx_t tgt,
                                   input phy_ext_pkg::reg16_t pg);
    ext_hit = (pg == `EXT_PAGE_VALUE) && (idx == tgt);
  endfunction

  // byte-lane and writable-bit merge of a 16-bit register
  function automatic phy_ext_pkg::reg16_t merge(
      input phy_ext_pkg::reg16_t old_v,
      input phy_ext_pkg::reg16_t new_v,
      input logic [1:0] strb,
      input phy_ext_pkg::reg16_t mask);
    phy_ext_pkg::reg16_t bm;
    bm = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old_v & ~bm) | (new_v & bm);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [STRAP_W-1:0] strap_meta_reg;
  logic [STRAP_W-1:0] strap_sync_reg;
  logic sd_meta_reg;
  logic sd_sync_reg;
  logic pz_meta_reg;
  logic pz_sync_reg;

  // two stages each, first stage feeds only the second
  always_ff @(posedge CLK_I) begin
    if (CE_I) begin
      strap_meta_reg <= CONFIG_STRAP_PINS_I;
      strap_sync_reg <= strap_meta_reg;
      sd_meta_reg <= SIGNAL_DETECT_INPUT_I;
      sd_sync_reg <= sd_meta_reg;
      pz_meta_reg <= PORT_ZERO_I;
      pz_sync_reg <= pz_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register storage declarations

  phy_ext_pkg::reg16_t page_reg;
  phy_ext_pkg::reg16_t loop_reg;
  phy_ext_pkg::reg16_t power_reg;
  logic [`CRC_CNT_W-1:0] crc_cnt_reg;
  logic pkt_seen_reg;

  //////////////////////////////////////////////////////////////////////
  // write channel

  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic aw_bad_reg;
  phy_ext_pkg::reg_idx_t aw_idx_reg;
  phy_ext_pkg::reg16_t wdata_reg;
  logic [1:0] wstrb_reg;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic aw_have_next;
  logic w_have_next;
  logic bvalid_next;

  // address and data are taken in either order, then written together
  always_comb begin
    aw_take = AWVALID_I && awready_reg;
    w_take = WVALID_I && wready_reg;
    wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
    aw_have_next = wr_fire ? 1'b0 : (aw_have_reg || aw_take);
    w_have_next = wr_fire ? 1'b0 : (w_have_reg || w_take);
    bvalid_next = wr_fire || (bvalid_reg && !BREADY_I);
  end

  // write handshake state
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_bad_reg <= 1'b0;
      aw_idx_reg <= 5'h00;
      wdata_reg <= 16'h0000;
      wstrb_reg <= 2'h0;
    end else if (CE_I) begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      bvalid_reg <= bvalid_next;
      awready_reg <= !aw_have_next && !bvalid_next;
      wready_reg <= !w_have_next && !bvalid_next;
      if (aw_take) begin
        aw_idx_reg <= AWADDR_I[6:2];
        aw_bad_reg <= addr_bad(AWADDR_I);
      end
      if (w_take) begin
        wdata_reg <= WDATA_I[15:0];
        wstrb_reg <= WSTRB_I[1:0];
      end
      if (wr_fire) begin
        bresp_reg <= aw_bad_reg ? `RESP_SLVERR : `RESP_OKAY;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read channel

  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic ar_take;
  logic ar_bad;
  logic crc_rd;
  logic rvalid_next;
  phy_ext_pkg::reg_idx_t ar_idx;
  phy_ext_pkg::reg16_t rd_val;
  phy_ext_pkg::reg16_t power_ro;

  // read decode; other words of the window read as zero
  always_comb begin
    ar_take = ARVALID_I && arready_reg;
    ar_idx = ARADDR_I[6:2];
    ar_bad = addr_bad(ARADDR_I);
    rvalid_next = ar_take || (rvalid_reg && !RREADY_I);
    power_ro = {8'h00, MEDIA_MODE_I, 4'h0, DOWNSHIFT_STATUS_I, 1'b0};
    crc_rd = ar_take && !ar_bad &&
             ext_hit(ar_idx, `IDX_GOOD_CRC, page_reg);
    rd_val = 16'h0000;
    if (ar_bad) begin
      rd_val = 16'h0000;
    end else if (ar_idx == `IDX_PAGE_SELECT) begin
      rd_val = page_reg;
    end else if (ext_hit(ar_idx, `IDX_GOOD_CRC, page_reg)) begin
      rd_val = {pkt_seen_reg, 1'b0, crc_cnt_reg};
    end else if (ext_hit(ar_idx, `IDX_LOOP_CTRL, page_reg)) begin
      rd_val = loop_reg & `LOOP_WMASK;
    end else if (ext_hit(ar_idx, `IDX_POWER_CTRL, page_reg)) begin
      rd_val = (power_reg & `POWER_WMASK) | power_ro;
    end
  end

  // read handshake state
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RESP_OKAY;
    end else if (CE_I) begin
      rvalid_reg <= rvalid_next;
      arready_reg <= !rvalid_next;
      if (ar_take) begin
        rdata_reg <= {16'h0000, rd_val};
        rresp_reg <= ar_bad ? `RESP_SLVERR : `RESP_OKAY;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // good-crc counter, cleared by its own read

  // a packet in the clearing cycle survives the clear
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      crc_cnt_reg <= '0;
      pkt_seen_reg <= 1'b0;
    end else if (CE_I) begin
      if (crc_rd) begin
        crc_cnt_reg <= GOOD_CRC_PKT_I ? 14'h0001 : 14'h0000;
        pkt_seen_reg <= GOOD_CRC_PKT_I;
      end else if (GOOD_CRC_PKT_I) begin
        crc_cnt_reg <= crc_cnt_reg + 14'h0001;
        pkt_seen_reg <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // control registers

  logic wr_ok;
  assign wr_ok = wr_fire && !aw_bad_reg;

  // page select, always at its own index
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      page_reg <= `PAGE_RESET;
    end else if (CE_I && wr_ok && aw_idx_reg == `IDX_PAGE_SELECT) begin
      page_reg <= merge(page_reg, wdata_reg, wstrb_reg, 16'hFFFF);
    end
  end

  // loopback, signal-detect and led control; straps fill reset values
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      loop_reg <= `LOOP_RESET;
      loop_reg[`F_BLINK] <= strap_sync_reg[`STRAP_BLINK];
      loop_reg[`F_SIGNAL_DETECT_INPUT_POL] <= strap_sync_reg[`STRAP_SIGNAL_DETECT_INPUT];
    end else if (CE_I && wr_ok &&
                 ext_hit(aw_idx_reg, `IDX_LOOP_CTRL, page_reg)) begin
      // fields all held here
      loop_reg <= merge(loop_reg, wdata_reg, wstrb_reg,
                        `LOOP_WMASK);
    end
  end

  // power-saving and link control; straps fill reset values
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      power_reg <= `POWER_RESET;
      power_reg[`F_ADDR_REV] <= strap_sync_reg[`STRAP_ADDR_REV];
      power_reg[`F_CLK_FAST] <= strap_sync_reg[`STRAP_CLK_FAST];
      power_reg[`F_DS_EN] <= strap_sync_reg[`STRAP_DS_EN];
    end else if (CE_I && wr_ok &&
                 ext_hit(aw_idx_reg, `IDX_POWER_CTRL, page_reg)) begin
      power_reg <= merge(power_reg, wdata_reg, wstrb_reg,
                         `POWER_WMASK);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // derived control outputs

  logic lb_override_reg;
  logic clk_fast_reg;
  logic signal_detect_input_reg;
  logic [2:0] ds_attempts_reg;

  // overrides, port-zero clock gate, polarity and attempt count
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      lb_override_reg <= 1'b0;
      clk_fast_reg <= 1'b0;
      signal_detect_input_reg <= 1'b0;
      ds_attempts_reg <= 3'h3;
    end else if (CE_I) begin
      lb_override_reg <= loop_reg[`F_MLB_EN] ||
                         loop_reg[`F_CLB_EN];
      clk_fast_reg <= power_reg[`F_CLK_FAST] && pz_sync_reg;
      signal_detect_input_reg <= sd_sync_reg ^ loop_reg[`F_SIGNAL_DETECT_INPUT_POL];
      ds_attempts_reg <= `DS_BASE +
                         {1'b0, power_reg[`F_DS_CTL+1:`F_DS_CTL]};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // output wiring

  assign AWREADY_O = awready_reg;
  assign WREADY_O = wready_reg;
  assign BVALID_O = bvalid_reg;
  assign BRESP_O = bresp_reg;
  assign ARREADY_O = arready_reg;
  assign RVALID_O = rvalid_reg;
  assign RDATA_O = rdata_reg;
  assign RRESP_O = rresp_reg;
  assign LED_EXT_MODE_O = loop_reg[`F_LED_HI:`F_LED_LO];
  assign LED_RESET_BLINK_O = loop_reg[`F_BLINK];
  assign MEDIA_LB_EN_O = loop_reg[`F_MLB_EN];
  assign MEDIA_LB_MODE_O = loop_reg[`F_MLB_MODE+1:`F_MLB_MODE];
  assign MAC_LB_EN_O = loop_reg[`F_CLB_EN];
  assign MAC_LB_MODE_O = loop_reg[`F_CLB_MODE+1:`F_CLB_MODE];
  assign LB_OVERRIDE_O = lb_override_reg;
  assign FAST_FAILURE_PIN_EN_O = loop_reg[`F_FAST_FAIL];
  assign MDI_MODE_O = loop_reg[`F_MDI+1:`F_MDI];
  assign SIGNAL_DETECT_INPUT_ACTIVE_LOW_O = loop_reg[`F_SIGNAL_DETECT_INPUT_POL];
  assign SIGNAL_DETECT_O = signal_detect_input_reg;
  assign CARRIER_EXT_DIS_O = power_reg[`F_CARRIER];
  assign SLEEP_SEL_O = power_reg[`F_SLEEP+1:`F_SLEEP];
  assign WAKE_SEL_O = power_reg[`F_WAKE+1:`F_WAKE];
  assign ADDR_REVERSAL_O = power_reg[`F_ADDR_REV];
  assign OUTPUT_CLOCK_FAST_O = clk_fast_reg;
  assign NO_PREAMBLE_EN_O = power_reg[`F_NO_PRE];
  assign DOWNSHIFT_EN_O = power_reg[`F_DS_EN];
  assign DOWNSHIFT_ATTEMPTS_O = ds_attempts_reg;

  //////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_crc_read;
    CE_I && crc_rd && !GOOD_CRC_PKT_I;
  endsequence

  sequence s_lb_write;
    CE_I && wr_ok && ext_hit(aw_idx_reg, `IDX_LOOP_CTRL, page_reg) &&
    wstrb_reg[1] && wdata_reg[`F_MLB_EN];
  endsequence

  a_crc_clear: assert property (s_crc_read |=>
    crc_cnt_reg == 14'h0000 && !pkt_seen_reg)
    else $error("good-crc count not cleared by read");

  a_crc_rdata: assert property (s_crc_read |=> RVALID_O &&
    RDATA_O[15:0] == {$past(pkt_seen_reg), 1'b0, $past(crc_cnt_reg)})
    else $error("good-crc read did not return prior value");

  a_crc_race: assert property (CE_I && crc_rd && GOOD_CRC_PKT_I |=>
    crc_cnt_reg == 14'h0001 && pkt_seen_reg)
    else $error("packet lost in clearing cycle");

  a_crc_wrap: assert property (CE_I && !crc_rd && GOOD_CRC_PKT_I &&
    crc_cnt_reg == 14'h3FFF |=> crc_cnt_reg == 14'h0000 && pkt_seen_reg)
    else $error("good-crc count did not wrap");

  a_page_gate: assert property (CE_I && ar_take && !ar_bad &&
    page_reg != `EXT_PAGE_VALUE && ar_idx == `IDX_POWER_CTRL |=>
    RDATA_O == 32'h0000_0000)
    else $error("extended register visible off its page");

  a_lb_override: assert property (s_lb_write ##1 CE_I |=>
    LB_OVERRIDE_O)
    else $error("loopback enable did not raise override");

  a_clk_port0: assert property (CE_I && !pz_sync_reg |=>
    !OUTPUT_CLOCK_FAST_O)
    else $error("fast output clock outside port zero");

  a_signal_detect_input_pol: assert property (CE_I && loop_reg[`F_SIGNAL_DETECT_INPUT_POL] &&
    sd_sync_reg |=> !SIGNAL_DETECT_O)
    else $error("active-low signal detect not inverted");

  a_ds_count: assert property (CE_I &&
    power_reg[`F_DS_CTL+1:`F_DS_CTL] == 2'h3 |=> DOWNSHIFT_ATTEMPTS_O == 3'h5)
    else $error("downshift attempt count wrong");

  a_reset_vals: assert property ($fell(RESET_I) |->
    SLEEP_SEL_O == 2'h1 && WAKE_SEL_O == 2'h3 &&
    power_reg[`F_DS_CTL+1:`F_DS_CTL] == 2'h1 && LED_EXT_MODE_O == 4'h0 &&
    SIGNAL_DETECT_INPUT_ACTIVE_LOW_O == $past(strap_sync_reg[`STRAP_SIGNAL_DETECT_INPUT]))
    else $error("reset values wrong");

  a_rvalid_hold: assert property (RVALID_O && !RREADY_I |=>
    RVALID_O && $stable(RDATA_O))
    else $error("read answer dropped before ready");

endmodule

// ==== verif/test_phy_extended_control_regs.sv ====
// self-checking bench for the extended control register bank
`timescale 1ns/1ps
`include "phy_ext_params.svh"
module test_phy_extended_control_regs;
  localparam logic [7:0] A_PAGE = {1'b0, `IDX_PAGE_SELECT, 2'b00};
  localparam logic [7:0] A_CRC = {1'b0, `IDX_GOOD_CRC, 2'b00};
  localparam logic [7:0] A_LOOP = {1'b0, `IDX_LOOP_CTRL, 2'b00};
  localparam logic [7:0] A_PWR = {1'b0, `IDX_POWER_CTRL, 2'b00};
  logic CLK_I, RESET_I, CE_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I;
  logic RREADY_I, GOOD_CRC_PKT_I, DOWNSHIFT_STATUS_I, PORT_ZERO_I;
  logic SIGNAL_DETECT_INPUT_I, AWREADY_O, WREADY_O, BVALID_O, ARREADY_O;
  logic RVALID_O, LED_RESET_BLINK_O, MEDIA_LB_EN_O, MAC_LB_EN_O;
  logic LB_OVERRIDE_O, FAST_FAILURE_PIN_EN_O, SIGNAL_DETECT_INPUT_ACTIVE_LOW_O;
  logic SIGNAL_DETECT_O, CARRIER_EXT_DIS_O, ADDR_REVERSAL_O;
  logic OUTPUT_CLOCK_FAST_O, NO_PREAMBLE_EN_O, DOWNSHIFT_EN_O;
  logic [7:0] AWADDR_I, ARADDR_I;
  logic [31:0] WDATA_I, RDATA_O;
  logic [3:0] WSTRB_I, LED_EXT_MODE_O;
  logic [1:0] MEDIA_MODE_I, BRESP_O, RRESP_O, MEDIA_LB_MODE_O;
  logic [1:0] MAC_LB_MODE_O, MDI_MODE_O, SLEEP_SEL_O, WAKE_SEL_O;
  logic [4:0] CONFIG_STRAP_PINS_I;
  logic [2:0] DOWNSHIFT_ATTEMPTS_O;
  int n_errors = 0;
  int checked = 0;

  ////////////////////////////////////////////////////////////////////////
  // device under test
  phy_extended_control_regs dut (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I),
    .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .AWADDR_I(AWADDR_I),
    .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .WDATA_I(WDATA_I),
    .WSTRB_I(WSTRB_I), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
    .BRESP_O(BRESP_O), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
    .ARADDR_I(ARADDR_I), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
    .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .GOOD_CRC_PKT_I(GOOD_CRC_PKT_I),
    .MEDIA_MODE_I(MEDIA_MODE_I), .DOWNSHIFT_STATUS_I(DOWNSHIFT_STATUS_I),
    .PORT_ZERO_I(PORT_ZERO_I), .CONFIG_STRAP_PINS_I(CONFIG_STRAP_PINS_I),
    .SIGNAL_DETECT_INPUT_I(SIGNAL_DETECT_INPUT_I),
    .LED_EXT_MODE_O(LED_EXT_MODE_O), .LED_RESET_BLINK_O(LED_RESET_BLINK_O),
    .MEDIA_LB_EN_O(MEDIA_LB_EN_O), .MEDIA_LB_MODE_O(MEDIA_LB_MODE_O),
    .MAC_LB_EN_O(MAC_LB_EN_O), .MAC_LB_MODE_O(MAC_LB_MODE_O),
    .LB_OVERRIDE_O(LB_OVERRIDE_O),
    .FAST_FAILURE_PIN_EN_O(FAST_FAILURE_PIN_EN_O),
    .MDI_MODE_O(MDI_MODE_O), .SIGNAL_DETECT_INPUT_ACTIVE_LOW_O(SIGNAL_DETECT_INPUT_ACTIVE_LOW_O),
    .SIGNAL_DETECT_O(SIGNAL_DETECT_O), .CARRIER_EXT_DIS_O(CARRIER_EXT_DIS_O),
    .SLEEP_SEL_O(SLEEP_SEL_O), .WAKE_SEL_O(WAKE_SEL_O),
    .ADDR_REVERSAL_O(ADDR_REVERSAL_O),
    .OUTPUT_CLOCK_FAST_O(OUTPUT_CLOCK_FAST_O),
    .NO_PREAMBLE_EN_O(NO_PREAMBLE_EN_O), .DOWNSHIFT_EN_O(DOWNSHIFT_EN_O),
    .DOWNSHIFT_ATTEMPTS_O(DOWNSHIFT_ATTEMPTS_O)
  );

  // 20 MHz clock
  always #25 CLK_I = ~CLK_I;

  ////////////////////////////////////////////////////////////////////////
  // compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // print counts and verdict, end the run
  task automatic summarize();
    $display("checks=%0d errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    bit aw, w, b;
    int n;
    aw = 0;
    w = 0;
    b = 0;
    n = 0;
    AWVALID_I <= 1'b1;
    AWADDR_I <= a;
    WVALID_I <= 1'b1;
    WDATA_I <= {16'hA5A5, d};
    WSTRB_I <= s;
    BREADY_I <= 1'b1;
    while (!b && n < 100) begin
      @(posedge CLK_I);
      n++;
      if (!aw && AWREADY_O) begin
        aw = 1;
        AWVALID_I <= 1'b0;
      end
      if (!w && WREADY_O) begin
        w = 1;
        WVALID_I <= 1'b0;
      end
      if (aw && w && BVALID_O && n > 1) begin
        b = 1;
        BREADY_I <= 1'b0;
        chk(BRESP_O, er);
      end
    end
    chk(b, 1);
    @(posedge CLK_I);
  endtask

  // axi4-lite read, optional packet pulse at the address edge
  task automatic rd(input logic [7:0] a, input logic p,
                    input logic [15:0] ed, input logic [1:0] er);
    bit ar, r;
    int n;
    ar = 0;
    r = 0;
    n = 0;
    ARVALID_I <= 1'b1;
    ARADDR_I <= a;
    RREADY_I <= 1'b1;
    GOOD_CRC_PKT_I <= p;
    while (!r && n < 100) begin
      @(posedge CLK_I);
      n++;
      GOOD_CRC_PKT_I <= 1'b0;
      if (ar && RVALID_O) begin
        r = 1;
        RREADY_I <= 1'b0;
        chk(RDATA_O, {16'h0000, ed});
        chk(RRESP_O, er);
      end
      if (!ar && ARREADY_O) begin
        ar = 1;
        ARVALID_I <= 1'b0;
      end
    end
    chk(r, 1);
    @(posedge CLK_I);
  endtask

  // burst of good-crc packet pulses
  task automatic pkts(input int cnt);
    GOOD_CRC_PKT_I <= 1'b1;
    repeat (cnt) @(posedge CLK_I);
    GOOD_CRC_PKT_I <= 1'b0;
    @(posedge CLK_I);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (40000) @(posedge CLK_I);
    n_errors++;
    summarize();
  end

  // main sequence
  initial begin
    logic [15:0] v;
    logic [1:0] kk;
    CLK_I = 0;
    RESET_I = 1;
    CE_I = 1;
    {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = '0;
    {AWADDR_I, ARADDR_I, WDATA_I, WSTRB_I, GOOD_CRC_PKT_I} = '0;
    CONFIG_STRAP_PINS_I = 5'h0D;
    PORT_ZERO_I = 1;
    MEDIA_MODE_I = 2'b10;
    DOWNSHIFT_STATUS_I = 1;
    SIGNAL_DETECT_INPUT_I = 1;
    repeat (10) @(posedge CLK_I);
    RESET_I <= 1'b0;
    @(posedge CLK_I);
    // paging and reset values
    rd(A_PAGE, 0, 16'h0000, `RESP_OKAY);
    rd(A_LOOP, 0, 16'h0000, `RESP_OKAY);
    wr(A_PAGE, `EXT_PAGE_VALUE, 4'h3, `RESP_OKAY);
    rd(A_LOOP, 0, 16'h0800, `RESP_OKAY);
    rd(A_PWR, 0, 16'h3996, `RESP_OKAY);
    chk(DOWNSHIFT_ATTEMPTS_O, 3);
    chk(OUTPUT_CLOCK_FAST_O, 1);
    chk(SIGNAL_DETECT_O, 1);
    $display("test reset_paging done");
    // loopback, crossover and polarity fields, every code; led field, one-hot codes only
    for (int k = 0; k < 4; k++) begin
      kk = k[1:0];
      v = {4'(1 << k), kk[0], kk[0], kk, ~kk[0], kk, kk[1], kk, 1'b1, kk[0]};
      wr(A_LOOP, v, 4'hF, `RESP_OKAY);
      rd(A_LOOP, 0, v & 16'hFFFD, `RESP_OKAY);
      chk(LED_EXT_MODE_O, v[15:12]);
      chk(LED_RESET_BLINK_O, kk[0]);
      chk({MEDIA_LB_EN_O, MEDIA_LB_MODE_O}, {kk[0], kk});
      chk({MAC_LB_EN_O, MAC_LB_MODE_O}, {~kk[0], kk});
      chk(LB_OVERRIDE_O, 1);
      chk(FAST_FAILURE_PIN_EN_O, kk[1]);
      chk(MDI_MODE_O, kk);
      chk({SIGNAL_DETECT_INPUT_ACTIVE_LOW_O, SIGNAL_DETECT_O}, {kk[0], ~kk[0]});
    end
    // active-low polarity with the pin low must report a detect
    SIGNAL_DETECT_INPUT_I <= 1'b0;
    repeat (4) @(posedge CLK_I);
    chk(SIGNAL_DETECT_O, 1);
    wr(A_LOOP, 16'hFFFF, 4'h1, `RESP_OKAY);
    rd(A_LOOP, 0, {v[15:8], 8'hFD}, `RESP_OKAY);
    wr(A_LOOP, 16'h0000, 4'h3, `RESP_OKAY);
    rd(A_LOOP, 0, 16'h0000, `RESP_OKAY);
    chk(LB_OVERRIDE_O, 0);
    chk(SIGNAL_DETECT_O, 0);
    $display("test loopback_control done");
    // power-saving register, every code, read-only bits kept
    for (int k = 0; k < 4; k++) begin
      kk = k[1:0];
      v = {kk[1], kk, kk, 1'b1, kk[0], kk[1], 2'b11, kk[0], kk[1], kk, 2'b11};
      // status inputs move too, so the read-only bits are really looked at
      MEDIA_MODE_I <= kk;
      DOWNSHIFT_STATUS_I <= kk[0];
      wr(A_PWR, v, 4'h3, `RESP_OKAY);
      rd(A_PWR, 0, (v & 16'hFB3C) | {8'h00, kk, 4'h0, kk[0], 1'b0},
         `RESP_OKAY);
      chk(ADDR_REVERSAL_O, kk[0]);
      chk(CARRIER_EXT_DIS_O, kk[1]);
      chk({SLEEP_SEL_O, WAKE_SEL_O}, {kk, kk});
      chk(OUTPUT_CLOCK_FAST_O, kk[1]);
      chk(NO_PREAMBLE_EN_O, kk[0]);
      chk(DOWNSHIFT_EN_O, kk[1]);
      chk(DOWNSHIFT_ATTEMPTS_O, 3'd2 + kk);
    end
    PORT_ZERO_I <= 1'b0;
    repeat (5) @(posedge CLK_I);
    chk(OUTPUT_CLOCK_FAST_O, 0);
    $display("test power_control done");
    // good-crc counter: count, clear on read, wrap, same-cycle event
    rd(A_CRC, 0, 16'h0000, `RESP_OKAY);
    pkts(5);
    rd(A_CRC, 0, 16'h8005, `RESP_OKAY);
    rd(A_CRC, 0, 16'h0000, `RESP_OKAY);
    wr(A_CRC, 16'h1234, 4'h3, `RESP_OKAY);
    rd(A_CRC, 0, 16'h0000, `RESP_OKAY);
    pkts(16385);
    rd(A_CRC, 0, 16'h8001, `RESP_OKAY);
    pkts(2);
    rd(A_CRC, 1, 16'h8002, `RESP_OKAY);
    rd(A_CRC, 0, 16'h8001, `RESP_OKAY);
    $display("test good_crc done");
    // bad addresses and leaving the extended page
    rd(8'h49, 0, 16'h0000, `RESP_SLVERR);
    wr(8'h4E, 16'hFFFF, 4'h3, `RESP_SLVERR);
    wr(8'h80, 16'hFFFF, 4'h3, `RESP_SLVERR);
    rd(A_LOOP, 0, 16'h0000, `RESP_OKAY);
    wr(A_PAGE, 16'h0000, 4'h3, `RESP_OKAY);
    rd(A_PWR, 0, 16'h0000, `RESP_OKAY);
    $display("test errors_paging done");
    summarize();
  end
endmodule
